// [hdl/cmd_select_pkg.sv]
// Package: register map, reset values, limits and codes for the command source selector
package cmd_select_pkg;

    // ------------------------------------------------------------
    // Register byte addresses (index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CARRIER    = 8'h00;
    localparam logic [7:0] REG_AUTO_FREQ  = 8'h04;
    localparam logic [7:0] REG_AUTO_RUN   = 8'h08;
    localparam logic [7:0] REG_DIR_PERM   = 8'h0C;
    localparam logic [7:0] REG_KP_MEM     = 8'h10;
    localparam logic [7:0] REG_LR_POLICY  = 8'h14;
    localparam logic [7:0] REG_HAND_FREQ  = 8'h18;
    localparam logic [7:0] REG_HAND_RUN   = 8'h1C;
    localparam logic [7:0] REG_STOP_GATE  = 8'h20;
    localparam logic [7:0] REG_PHASE      = 8'h24;
    localparam logic [7:0] REG_CUR_FILT   = 8'h28;
    localparam logic [7:0] REG_KP_FILT    = 8'h2C;
    localparam logic [7:0] REG_SW_DATE    = 8'h30;
    localparam logic [7:0] REG_STOP_MODE  = 8'h34;
    localparam logic [7:0] REG_STATUS     = 8'h38;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] CARRIER_RST   = 16'h0002;
    localparam logic [15:0] CARRIER_MIN   = 16'h0002;
    localparam logic [15:0] CARRIER_MAX   = 16'h0009;
    localparam logic [15:0] FILT_RST      = 16'h0064;
    localparam logic [15:0] FILT_MIN      = 16'h0001;
    localparam logic [15:0] SW_DATE_VALUE = 16'h1234;  // Arbitrary value

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [15:0] FSRC_KEYPAD = 16'h0000;
    localparam logic [15:0] FSRC_RS485  = 16'h0001;
    localparam logic [15:0] FSRC_UPDOWN = 16'h0003;
    localparam logic [15:0] FSRC_CAN    = 16'h0006;
    localparam logic [15:0] RSRC_KEYPAD = 16'h0000;
    localparam logic [15:0] RSRC_TERM   = 16'h0001;
    localparam logic [15:0] RSRC_RS485  = 16'h0002;
    localparam logic [15:0] RSRC_CAN    = 16'h0003;
    localparam logic [15:0] RSRC_MAX    = 16'h0003;
    localparam logic [15:0] DIR_BOTH    = 16'h0000;
    localparam logic [15:0] DIR_NO_REV  = 16'h0001;
    localparam logic [15:0] DIR_NO_FWD  = 16'h0002;
    localparam logic [15:0] DIR_MAX     = 16'h0002;
    localparam logic [15:0] LR_HOA      = 16'h0000;
    localparam logic [15:0] LR_STOP     = 16'h0001;
    localparam logic [15:0] LR_REMOTE   = 16'h0002;
    localparam logic [15:0] LR_LOCAL    = 16'h0003;
    localparam logic [15:0] LR_ENTERED  = 16'h0004;
    localparam logic [15:0] ONE_BIT_MAX = 16'h0001;

    // Run channel of one source
    typedef struct packed {
        logic run;
        logic reverse_indicator;
        logic jog;
    } run_cmd_t;

    typedef enum logic {
        MODE_AUTO,
        MODE_HAND
    } mode_t;

endpackage

// [hdl/cmd_select.sv]
// Command source selection and run control for a compact motor drive
`timescale 1ns/1ps
module cmd_select
    import cmd_select_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic [15:0] FREQ_KEYPAD,
    input  wire logic [15:0] FREQ_RS485,
    input  wire logic [15:0] FREQ_UPDOWN,
    input  wire logic [15:0] FREQ_CAN,
    input  wire run_cmd_t    RUN_KEYPAD,
    input  wire run_cmd_t    RUN_TERM,
    input  wire run_cmd_t    RUN_RS485,
    input  wire run_cmd_t    RUN_CAN,
    input  wire logic        PANEL_COMM_RUN_KEY,
    input  wire logic        KEYPAD_STOP_KEY,
    input  wire logic        HOA_HAND_INPUT,
    input  wire logic        HOA_AUTO_INPUT,
    input  wire logic        MODE_SWITCH_ASSIGNED,
    input  wire logic        MODE_SWITCH_INPUT,
    input  wire logic        LOCAL_REMOTE_SELECT,
    input  wire logic        UNDERVOLTAGE_CONDITION,
    input  wire logic        FAULT,
    input  wire logic        AT_MIN_FREQ,
    output logic      [15:0] FREQ_CMD,
    output logic             OUTPUT_ENABLE,
    output logic             DECEL_ACTIVE,
    output logic             MOTOR_REVERSE,
    output logic             FORWARD_INDICATOR,
    output logic             REVERSE_INDICATOR,
    output logic             JOG_ACTIVE,
    output logic             HAND_MODE,
    output logic      [15:0] CARRIER_KHZ,
    output logic      [15:0] CURRENT_FILTER_MS,
    output logic      [15:0] KEYPAD_FILTER_MS
);

    // ------------------------------------------------------------
    // Setting registers
    // ------------------------------------------------------------
    logic [15:0] carrier, auto_freq, auto_run, dir_perm, kp_mem, lr_policy;
    logic [15:0] hand_freq, hand_run, stop_gate, phase, cur_filt, kp_filt;
    logic        stop_mode;
    logic        reg_wr_ok;

    function automatic logic fsrc_ok(input logic [15:0] v);
        return v == FSRC_KEYPAD || v == FSRC_RS485 || v == FSRC_UPDOWN || v == FSRC_CAN;
    endfunction

    always_comb begin
        unique case (ADDR)
            REG_CARRIER:   reg_wr_ok = WDATA >= CARRIER_MIN && WDATA <= CARRIER_MAX;
            REG_AUTO_FREQ: reg_wr_ok = fsrc_ok(WDATA);
            REG_HAND_FREQ: reg_wr_ok = fsrc_ok(WDATA);
            REG_AUTO_RUN:  reg_wr_ok = WDATA <= RSRC_MAX;
            REG_HAND_RUN:  reg_wr_ok = WDATA <= RSRC_MAX;
            REG_DIR_PERM:  reg_wr_ok = WDATA <= DIR_MAX;
            REG_LR_POLICY: reg_wr_ok = WDATA <= LR_ENTERED;
            REG_STOP_GATE: reg_wr_ok = WDATA <= ONE_BIT_MAX;
            REG_PHASE:     reg_wr_ok = WDATA <= ONE_BIT_MAX;
            REG_STOP_MODE: reg_wr_ok = WDATA <= ONE_BIT_MAX;
            REG_CUR_FILT:  reg_wr_ok = WDATA >= FILT_MIN;
            REG_KP_FILT:   reg_wr_ok = WDATA >= FILT_MIN;
            default:       reg_wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            carrier   <= CARRIER_RST;
            auto_freq <= FSRC_CAN;
            auto_run  <= RSRC_CAN;
            hand_freq <= FSRC_CAN;
            hand_run  <= RSRC_CAN;
            dir_perm  <= DIR_BOTH;
            lr_policy <= LR_HOA;
            stop_gate <= 16'h0000;
            phase     <= 16'h0000;
            stop_mode <= 1'b0;
            cur_filt  <= FILT_RST;
            kp_filt   <= FILT_RST;
        end else if (WR && reg_wr_ok) begin
            unique case (ADDR)
                REG_CARRIER:   carrier   <= WDATA;
                REG_AUTO_FREQ: auto_freq <= WDATA;
                REG_AUTO_RUN:  auto_run  <= WDATA;
                REG_HAND_FREQ: hand_freq <= WDATA;
                REG_HAND_RUN:  hand_run  <= WDATA;
                REG_DIR_PERM:  dir_perm  <= WDATA;
                REG_LR_POLICY: lr_policy <= WDATA;
                REG_STOP_GATE: stop_gate <= WDATA;
                REG_PHASE:     phase     <= WDATA;
                REG_STOP_MODE: stop_mode <= WDATA[0];
                REG_CUR_FILT:  cur_filt  <= WDATA;
                REG_KP_FILT:   kp_filt   <= WDATA;
                default:       stop_mode <= stop_mode;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    mode_t mode;
    mode_t prev_mode;
    mode_t next_mode;
    logic  policy_mode_hand;

    // Function 56 is ignored under the plain hand-off-auto policy
    always_comb begin
        policy_mode_hand = (lr_policy != LR_HOA) ? LOCAL_REMOTE_SELECT : HOA_HAND_INPUT;
        if (MODE_SWITCH_ASSIGNED)
            next_mode = MODE_SWITCH_INPUT ? MODE_HAND : MODE_AUTO;
        else
            next_mode = policy_mode_hand ? MODE_HAND : MODE_AUTO;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode      <= MODE_AUTO;
            prev_mode <= MODE_AUTO;
        end else begin
            mode      <= next_mode;
            prev_mode <= mode;
        end
    end

    // Policies 2 and 3 pin the source set; 0, 1 and 4 follow the mode entered
    logic use_hand;
    always_comb begin
        unique case (lr_policy)
            LR_REMOTE: use_hand = 1'b0;
            LR_LOCAL:  use_hand = 1'b1;
            default:   use_hand = (mode == MODE_HAND);
        endcase
    end

    // Switch-over stop latch under policy 1, released by a fresh run edge
    logic switch_stop;
    logic run_sel_q;

    // ------------------------------------------------------------
    // Source multiplexers
    // ------------------------------------------------------------
    logic [15:0] fsrc, rsrc, freq_sel;
    run_cmd_t    run_sel;

    always_comb begin
        fsrc = use_hand ? hand_freq : auto_freq;
        rsrc = use_hand ? hand_run : auto_run;
        unique case (fsrc)
            FSRC_KEYPAD: freq_sel = FREQ_KEYPAD;
            FSRC_RS485:  freq_sel = FREQ_RS485;
            FSRC_UPDOWN: freq_sel = FREQ_UPDOWN;
            default:     freq_sel = FREQ_CAN;
        endcase
        unique case (rsrc)
            RSRC_KEYPAD: run_sel = RUN_KEYPAD;
            RSRC_TERM:   run_sel = RUN_TERM;
            RSRC_RS485:  run_sel = RUN_RS485;
            default:     begin
                run_sel     = RUN_CAN;
                run_sel.run = RUN_CAN.run | PANEL_COMM_RUN_KEY;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Run and stop control
    // ------------------------------------------------------------
    logic hoa_off, stop_key, run_req, dir_allowed, running;

    always_comb begin
        hoa_off  = (lr_policy == LR_HOA) && !HOA_HAND_INPUT && !HOA_AUTO_INPUT;
        stop_key = KEYPAD_STOP_KEY && (rsrc == RSRC_KEYPAD || stop_gate[0]);
        run_req  = run_sel.run && !hoa_off && !stop_key && !switch_stop
                   && !(lr_policy == LR_STOP && mode != prev_mode);
        unique case (dir_perm)
            DIR_NO_REV: dir_allowed = !run_sel.reverse_indicator;
            DIR_NO_FWD: dir_allowed = run_sel.reverse_indicator;
            default:    dir_allowed = 1'b1;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            switch_stop <= 1'b0;
            run_sel_q   <= 1'b0;
        end else begin
            run_sel_q <= run_sel.run;
            if (lr_policy == LR_STOP && mode != prev_mode)
                switch_stop <= 1'b1;
            else if (run_sel.run && !run_sel_q)
                switch_stop <= 1'b0;
        end
    end

    assign running = run_req && dir_allowed;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            OUTPUT_ENABLE     <= 1'b0;
            DECEL_ACTIVE      <= 1'b0;
            MOTOR_REVERSE     <= 1'b0;
            FORWARD_INDICATOR <= 1'b0;
            REVERSE_INDICATOR <= 1'b0;
            JOG_ACTIVE        <= 1'b0;
            FREQ_CMD          <= 16'h0000;
        end else if (running) begin
            OUTPUT_ENABLE     <= 1'b1;
            DECEL_ACTIVE      <= 1'b0;
            MOTOR_REVERSE     <= run_sel.reverse_indicator ^ phase[0];
            FORWARD_INDICATOR <= !run_sel.reverse_indicator;
            REVERSE_INDICATOR <= run_sel.reverse_indicator;
            JOG_ACTIVE        <= run_sel.jog;
            FREQ_CMD          <= freq_sel;
        end else begin
            // Forbidden direction leaves a stopped drive stopped
            JOG_ACTIVE <= 1'b0;
            if (stop_mode || !OUTPUT_ENABLE || (DECEL_ACTIVE && AT_MIN_FREQ)) begin
                OUTPUT_ENABLE     <= 1'b0;
                DECEL_ACTIVE      <= 1'b0;
                FORWARD_INDICATOR <= 1'b0;
                REVERSE_INDICATOR <= 1'b0;
            end else begin
                DECEL_ACTIVE <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Keypad frequency memory
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            kp_mem <= 16'h0000;
        else if (fsrc == FSRC_KEYPAD && (UNDERVOLTAGE_CONDITION || FAULT))
            kp_mem <= FREQ_KEYPAD;
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            RDATA <= 16'h0000;
        else if (RD) begin
            unique case (ADDR)
                REG_CARRIER:   RDATA <= carrier;
                REG_AUTO_FREQ: RDATA <= auto_freq;
                REG_AUTO_RUN:  RDATA <= auto_run;
                REG_DIR_PERM:  RDATA <= dir_perm;
                REG_KP_MEM:    RDATA <= kp_mem;
                REG_LR_POLICY: RDATA <= lr_policy;
                REG_HAND_FREQ: RDATA <= hand_freq;
                REG_HAND_RUN:  RDATA <= hand_run;
                REG_STOP_GATE: RDATA <= stop_gate;
                REG_PHASE:     RDATA <= phase;
                REG_CUR_FILT:  RDATA <= cur_filt;
                REG_KP_FILT:   RDATA <= kp_filt;
                REG_SW_DATE:   RDATA <= SW_DATE_VALUE;
                REG_STOP_MODE: RDATA <= {15'h0000, stop_mode};
                REG_STATUS:    RDATA <= {12'h000, DECEL_ACTIVE, OUTPUT_ENABLE,
                                         use_hand, mode == MODE_HAND};
                default:       RDATA <= 16'h0000;
            endcase
        end else
            RDATA <= 16'h0000;
    end

    assign HAND_MODE         = (mode == MODE_HAND);
    assign CARRIER_KHZ       = carrier;
    assign CURRENT_FILTER_MS = cur_filt;
    assign KEYPAD_FILTER_MS  = kp_filt;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_carrier_range: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        carrier >= CARRIER_MIN && carrier <= CARRIER_MAX) else $error("carrier out of range");
    chk_bad_code_kept: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        WR && ADDR == REG_AUTO_FREQ && !fsrc_ok(WDATA) |=> $stable(auto_freq))
        else $error("illegal frequency code stored");
    chk_mode_override: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        MODE_SWITCH_ASSIGNED && MODE_SWITCH_INPUT |=> HAND_MODE) else $error("override lost");
    chk_hoa_off_run: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        hoa_off && !OUTPUT_ENABLE |=> !OUTPUT_ENABLE && !JOG_ACTIVE)
        else $error("run taken with hand-off-auto off");
    chk_coast_stop: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        stop_mode && !running |=> !OUTPUT_ENABLE) else $error("coast stop kept output");
    chk_ramp_stop: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !stop_mode && !running && OUTPUT_ENABLE && !DECEL_ACTIVE |=> OUTPUT_ENABLE && DECEL_ACTIVE)
        else $error("ramp stop did not decelerate");
    chk_dir_forbid: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $past(dir_perm) == DIR_NO_REV && OUTPUT_ENABLE && !DECEL_ACTIVE |-> !REVERSE_INDICATOR)
        else $error("reverse ran while forbidden");
    chk_phase_swap: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        OUTPUT_ENABLE && !DECEL_ACTIVE |-> MOTOR_REVERSE == (REVERSE_INDICATOR ^ $past(phase[0])))
        else $error("phase order wrong");
    chk_kp_latch: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        fsrc == FSRC_KEYPAD && (UNDERVOLTAGE_CONDITION || FAULT) |=> kp_mem == $past(FREQ_KEYPAD))
        else $error("keypad frequency not latched");
    cov_coast: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        OUTPUT_ENABLE ##1 !OUTPUT_ENABLE);
    cov_ramp: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        DECEL_ACTIVE ##[1:20] !OUTPUT_ENABLE);
    cov_hand: cover property (@(posedge CLK_SYS) disable iff (!RST_N) HAND_MODE && running);

endmodule

// [tb/drive_sources.sv]
// Behavioural keypad, terminals and fieldbus masters for the selector bench
`timescale 1ns/1ps
module drive_sources
    import cmd_select_pkg::*;
(
    input  wire logic [1:0]  run_src,
    input  wire logic        run_on,
    input  wire logic        reverse_indicator,
    input  wire logic        jog,
    output logic      [15:0] freq_keypad,
    output logic      [15:0] freq_rs485,
    output logic      [15:0] freq_updown,
    output logic      [15:0] freq_can,
    output run_cmd_t         run_keypad,
    output run_cmd_t         run_term,
    output run_cmd_t         run_rs485,
    output run_cmd_t         run_can
);
    run_cmd_t cmd;
    // ----------------------------------------
    // Sources
    // ----------------------------------------
    // Distinct levels, so a wrong mux leg shows at once
    assign freq_keypad = 16'h0111;
    assign freq_rs485  = 16'h0222;
    assign freq_updown = 16'h0333;
    assign freq_can    = 16'h0444;
    assign cmd         = '{run: run_on, reverse_indicator: reverse_indicator, jog: jog};
    // Idle sources drop every line, never a stale copy
    assign run_keypad  = (run_src == 2'h0) ? cmd : '0;
    assign run_term    = (run_src == 2'h1) ? cmd : '0;
    assign run_rs485   = (run_src == 2'h2) ? cmd : '0;
    assign run_can     = (run_src == 2'h3) ? cmd : '0;
endmodule

// [tb/cmd_select_bench.sv]
// Self-checking bench for the command source selector
`timescale 1ns/1ps
module cmd_select_bench
    import cmd_select_pkg::*;
    ;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [1:0]  run_src = 2'h0;
    logic        run_on = 1'b0;
    logic        run_rev = 1'b0;
    logic        run_jog = 1'b0;
    logic        panel = 1'b0;
    logic        stop_key = 1'b0;
    logic        hoa_auto = 1'b0;
    logic        mode_asg = 1'b0;
    logic        mode_in = 1'b0;
    logic        uv = 1'b0;
    logic        fault = 1'b0;
    logic        hoa_hand = 1'b0;
    logic        lr_sel = 1'b0;
    logic        at_min = 1'b0;
    logic [15:0] rdata, freq_cmd, carrier, cur_filt, kp_filt, f_kp, f_485, f_ud, f_can;
    logic        oe, decel, mrev, fwd_ind, rev_ind, jog_act, hand_mode;
    run_cmd_t    r_kp, r_term, r_485, r_can;
    int          error_cnt = 0;
    int          compares = 0;
    logic [7:0]  ra [14] = '{REG_CARRIER, REG_AUTO_FREQ, REG_AUTO_RUN, REG_DIR_PERM,
        REG_LR_POLICY, REG_HAND_FREQ, REG_HAND_RUN, REG_STOP_GATE, REG_PHASE,
        REG_CUR_FILT, REG_KP_FILT, REG_SW_DATE, REG_STOP_MODE, 8'h3C};
    logic [15:0] rv [14] = '{16'h0002, 16'h0006, 16'h0003, 16'h0000, 16'h0000, 16'h0006,
        16'h0003, 16'h0000, 16'h0000, FILT_RST, FILT_RST, SW_DATE_VALUE, 16'h0000, 16'h0000};
    logic [15:0] fc [4] = '{FSRC_RS485, FSRC_UPDOWN, FSRC_CAN, FSRC_KEYPAD};
    logic [15:0] fv [4] = '{16'h0222, 16'h0333, 16'h0444, 16'h0111};

    cmd_select uut (.CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .FREQ_KEYPAD(f_kp), .FREQ_RS485(f_485),
        .FREQ_UPDOWN(f_ud), .FREQ_CAN(f_can), .RUN_KEYPAD(r_kp), .RUN_TERM(r_term),
        .RUN_RS485(r_485), .RUN_CAN(r_can), .PANEL_COMM_RUN_KEY(panel),
        .KEYPAD_STOP_KEY(stop_key), .HOA_HAND_INPUT(hoa_hand), .HOA_AUTO_INPUT(hoa_auto),
        .MODE_SWITCH_ASSIGNED(mode_asg), .MODE_SWITCH_INPUT(mode_in),
        .LOCAL_REMOTE_SELECT(lr_sel), .UNDERVOLTAGE_CONDITION(uv), .FAULT(fault),
        .AT_MIN_FREQ(at_min), .FREQ_CMD(freq_cmd), .OUTPUT_ENABLE(oe),
        .DECEL_ACTIVE(decel), .MOTOR_REVERSE(mrev), .FORWARD_INDICATOR(fwd_ind),
        .REVERSE_INDICATOR(rev_ind), .JOG_ACTIVE(jog_act), .HAND_MODE(hand_mode),
        .CARRIER_KHZ(carrier), .CURRENT_FILTER_MS(cur_filt), .KEYPAD_FILTER_MS(kp_filt));
    drive_sources far (.run_src(run_src), .run_on(run_on), .reverse_indicator(run_rev), .jog(run_jog),
        .freq_keypad(f_kp), .freq_rs485(f_485), .freq_updown(f_ud), .freq_can(f_can),
        .run_keypad(r_kp), .run_term(r_term), .run_rs485(r_485), .run_can(r_can));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk_val($sformatf("reg %h", a), exp, rdata);
    endtask
    // Two edges of margin: mode flop plus output register
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic drive(input logic [1:0] s, input logic on, input logic r);
        @(posedge clk);
        run_src <= s;
        run_on <= on;
        run_rev <= r;
        settle();
    endtask
    task automatic finish_test;
        $display("Comparisons %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_val("hand_mode", 16'h0000, {15'h0, hand_mode});
        chk_val("carrier", 16'h0002, carrier);
        chk_val("cur_filt", FILT_RST, cur_filt);
        for (int i = 0; i < 14; i++) rd_chk(ra[i], rv[i]);
        wr_reg(REG_AUTO_FREQ, 16'h0002);
        rd_chk(REG_AUTO_FREQ, 16'h0006);
        wr_reg(REG_CARRIER, 16'h000A);
        rd_chk(REG_CARRIER, 16'h0002);
        wr_reg(REG_CARRIER, 16'h0009);
        rd_chk(REG_CARRIER, 16'h0009);
        wr_reg(REG_KP_FILT, 16'h0000);
        rd_chk(REG_KP_FILT, FILT_RST);
        wr_reg(REG_KP_FILT, 16'hFFFF);
        rd_chk(REG_KP_FILT, 16'hFFFF);
        chk_val("kp_filt", 16'hFFFF, kp_filt);
        wr_reg(REG_DIR_PERM, 16'h0003);
        rd_chk(REG_DIR_PERM, 16'h0000);
        wr_reg(REG_LR_POLICY, 16'h0005);
        rd_chk(REG_LR_POLICY, 16'h0000);
        // Coast stop keeps each source check short
        wr_reg(REG_STOP_MODE, 16'h0001);
        hoa_auto <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr_reg(REG_AUTO_RUN, 16'(c));
            drive(2'(c + 1), 1'b1, 1'b0);
            chk_val("oe other src", 16'h0000, {15'h0, oe});
            drive(2'(c), 1'b1, 1'b0);
            chk_val("oe own src", 16'h0001, {15'h0, oe});
            chk_val("fwd_ind", 16'h0001, {15'h0, fwd_ind});
            drive(2'(c), 1'b0, 1'b0);
            chk_val("oe coast", 16'h0000, {15'h0, oe});
        end
        @(posedge clk);
        fault <= 1'b1;
        settle();
        @(posedge clk);
        fault <= 1'b0;
        rd_chk(REG_KP_MEM, 16'h0000);
        drive(2'h3, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr_reg(REG_AUTO_FREQ, fc[i]);
            settle();
            chk_val("freq_cmd", fv[i], freq_cmd);
        end
        @(posedge clk);
        uv <= 1'b1;
        settle();
        @(posedge clk);
        uv <= 1'b0;
        rd_chk(REG_KP_MEM, 16'h0111);
        wr_reg(REG_AUTO_FREQ, FSRC_CAN);
        stop_key <= 1'b1;
        settle();
        chk_val("oe stop gated off", 16'h0001, {15'h0, oe});
        @(posedge clk);
        stop_key <= 1'b0;
        wr_reg(REG_STOP_GATE, 16'h0001);
        stop_key <= 1'b1;
        settle();
        chk_val("oe stop gated on", 16'h0000, {15'h0, oe});
        drive(2'h3, 1'b0, 1'b0);
        @(posedge clk);
        stop_key <= 1'b0;
        panel <= 1'b1;
        settle();
        chk_val("oe panel key", 16'h0001, {15'h0, oe});
        @(posedge clk);
        panel <= 1'b0;
        hoa_auto <= 1'b0;
        run_jog <= 1'b1;
        drive(2'h3, 1'b1, 1'b0);
        chk_val("oe hoa off", 16'h0000, {15'h0, oe});
        chk_val("jog hoa off", 16'h0000, {15'h0, jog_act});
        @(posedge clk);
        hoa_hand <= 1'b1;
        settle();
        chk_val("jog hoa hand", 16'h0001, {15'h0, jog_act});
        chk_val("hoa hand mode", 16'h0001, {15'h0, hand_mode});
        @(posedge clk);
        hoa_hand <= 1'b0;
        hoa_auto <= 1'b1;
        run_jog <= 1'b0;
        drive(2'h3, 1'b0, 1'b0);
        wr_reg(REG_DIR_PERM, DIR_NO_REV);
        drive(2'h3, 1'b1, 1'b1);
        chk_val("oe no rev", 16'h0000, {15'h0, oe});
        drive(2'h3, 1'b0, 1'b0);
        wr_reg(REG_DIR_PERM, DIR_BOTH);
        wr_reg(REG_PHASE, 16'h0001);
        drive(2'h3, 1'b1, 1'b1);
        chk_val("mrev rev", 16'h0000, {15'h0, mrev});
        chk_val("rev_ind", 16'h0001, {15'h0, rev_ind});
        drive(2'h3, 1'b1, 1'b0);
        chk_val("mrev fwd", 16'h0001, {15'h0, mrev});
        drive(2'h3, 1'b0, 1'b0);
        wr_reg(REG_PHASE, 16'h0000);
        wr_reg(REG_DIR_PERM, DIR_NO_FWD);
        drive(2'h3, 1'b1, 1'b0);
        chk_val("oe no fwd", 16'h0000, {15'h0, oe});
        drive(2'h3, 1'b0, 1'b0);
        wr_reg(REG_DIR_PERM, DIR_BOTH);
        wr_reg(REG_STOP_MODE, 16'h0000);
        drive(2'h3, 1'b1, 1'b0);
        drive(2'h3, 1'b0, 1'b0);
        chk_val("decel", 16'h0001, {15'h0, decel});
        chk_val("oe ramp", 16'h0001, {15'h0, oe});
        @(posedge clk);
        at_min <= 1'b1;
        settle();
        chk_val("oe ramp end", 16'h0000, {15'h0, oe});
        @(posedge clk);
        at_min <= 1'b0;
        wr_reg(REG_HAND_FREQ, FSRC_RS485);
        mode_asg <= 1'b1;
        mode_in <= 1'b1;
        drive(2'h3, 1'b1, 1'b0);
        chk_val("hand_mode", 16'h0001, {15'h0, hand_mode});
        chk_val("freq hand", 16'h0222, freq_cmd);
        wr_reg(REG_HAND_RUN, RSRC_RS485);
        drive(2'h2, 1'b1, 1'b0);
        chk_val("oe hand run", 16'h0001, {15'h0, oe});
        chk_val("decel hand run", 16'h0000, {15'h0, decel});
        @(posedge clk);
        mode_in <= 1'b0;
        settle();
        chk_val("hand_mode off", 16'h0000, {15'h0, hand_mode});
        // Local/remote policies, override input released
        @(posedge clk);
        mode_asg <= 1'b0;
        lr_sel <= 1'b1;
        settle();
        chk_val("lr ignored", 16'h0000, {15'h0, hand_mode});
        wr_reg(REG_LR_POLICY, LR_REMOTE);
        drive(2'h3, 1'b1, 1'b0);
        chk_val("lr hand", 16'h0001, {15'h0, hand_mode});
        chk_val("freq remote", 16'h0444, freq_cmd);
        wr_reg(REG_LR_POLICY, LR_LOCAL);
        drive(2'h2, 1'b1, 1'b0);
        chk_val("freq local", 16'h0222, freq_cmd);
        wr_reg(REG_LR_POLICY, LR_STOP);
        @(posedge clk);
        lr_sel <= 1'b0;
        run_src <= 2'h3;
        settle();
        chk_val("decel on switch", 16'h0001, {15'h0, decel});
        settle();
        chk_val("stop latched", 16'h0001, {15'h0, decel});
        drive(2'h3, 1'b0, 1'b0);
        drive(2'h3, 1'b1, 1'b0);
        chk_val("oe fresh run", 16'h0001, {15'h0, oe});
        chk_val("decel fresh run", 16'h0000, {15'h0, decel});
        finish_test();
    end
endmodule
